// ==== hdl/lds_sequencer.sv ====
// Our own choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
module lds_sequencer
#(
  parameter int FLOOR_W = 5,
  parameter int TICK_CYCLES = lds_pkg::TICK_CYC
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [1:0] mode_sel_pin,
  input wire logic jog_up_pin,
  input wire logic jog_down_pin,
  input wire logic open_limit_pin,
  input wire logic close_limit_pin,
  input wire logic open_btn_pin,
  input wire logic close_btn_pin,
  input wire logic delay_btn_pin,
  input wire logic curtain_pin,
  input wire logic key_lock_input,
  input wire logic fire_switch_input,
  input wire logic fireman_switch_pin,
  input wire logic landing_call_pin,
  input wire logic car_call_pin,
  input wire logic running_pin,
  input wire logic at_floor_pin,
  input wire logic [FLOOR_W-1:0] floor_pin,
  output logic brake_release,
  output logic torque_hold,
  output logic door_open_cmd,
  output logic door_close_cmd,
  output logic door_fault,
  output logic stop_nearest,
  output logic cancel_calls,
  output logic goto_req,
  output logic [FLOOR_W-1:0] goto_floor,
  output logic service_locked,
  output logic one_call_only
);
  localparam int NS = 16;
  // Synchronised pins, bit order fixed below
  logic [NS-1:0] raw;
  assign raw = {running_pin, at_floor_pin, car_call_pin, landing_call_pin, fireman_switch_pin,
                fire_switch_input, key_lock_input, curtain_pin, delay_btn_pin, close_btn_pin,
                open_btn_pin, close_limit_pin, open_limit_pin, jog_down_pin, jog_up_pin,
                1'b0};

  // All state in one struct
  typedef struct packed {
    logic [NS-1:0] s1;
    logic [NS-1:0] s2;
    logic [1:0] mode1;
    logic [1:0] mode2;
    logic [FLOOR_W-1:0] flr1;
    logic [FLOOR_W-1:0] flr2;
    logic [31:0] tick_cnt;
    logic tick;
    logic [15:0] t_motion;
    logic [15:0] t_hold;
    logic [15:0] t_delay;
    logic [15:0] t_brake;
    logic [15:0] t_home;
    logic [31:0] floors;
    logic [31:0] config_r;
    logic clk_stop;
    lds_pkg::lds_door_t door;
    logic [15:0] door_cnt;
    logic delay_used;
    logic [15:0] brake_cnt;
    logic jog_prev;
    logic [15:0] home_cnt;
    logic fault;
    logic close_latch;
    lds_pkg::lds_fire_t fire;
    logic oper_left;
    logic key_prev;
    logic temp_run;
    logic stop_prev; // Car was standing at a floor last cycle
    logic land_req; // Fresh landing still waiting to open the door
    logic [31:0] rdata;
    logic rvalid;
  } lds_state_t;

  lds_state_t st_q;
  lds_state_t st_d;

  // Sync view of the second stage only
  logic s_jog;
  logic s_olim;
  logic s_clim;
  logic s_obtn;
  logic s_cbtn;
  logic s_dbtn;
  logic s_curt;
  logic s_key;
  logic s_fire;
  logic s_fman;
  logic s_lc;
  logic s_cc;
  logic s_atf;
  logic s_run;
  lds_pkg::lds_mode_t mode;
  logic [FLOOR_W-1:0] home_f;
  logic [FLOOR_W-1:0] park_f;
  logic [FLOOR_W-1:0] fire_f;
  logic [1:0] fsel;
  logic in_fire;
  logic fire_floor;
  logic parked;
  logic [15:0] hold_sel;

  assign s_jog = st_q.s2[1] | st_q.s2[2];
  assign s_olim = st_q.s2[3];
  assign s_clim = st_q.s2[4];
  assign s_obtn = st_q.s2[5];
  assign s_cbtn = st_q.s2[6];
  assign s_dbtn = st_q.s2[7];
  assign s_curt = st_q.s2[8];
  assign s_key = st_q.s2[9];
  assign s_fire = st_q.s2[10];
  assign s_fman = st_q.s2[11];
  assign s_lc = st_q.s2[12];
  assign s_cc = st_q.s2[13];
  assign s_atf = st_q.s2[14];
  assign s_run = st_q.s2[15];
  assign mode = (st_q.mode2 == 2'h1) ? lds_pkg::LDS_ATTEND :
                (st_q.mode2 == 2'h2) ? lds_pkg::LDS_INSP : lds_pkg::LDS_AUTO;
  assign home_f = st_q.floors[FLOOR_W-1:0];
  assign park_f = st_q.floors[8+:FLOOR_W];
  assign fire_f = st_q.floors[16+:FLOOR_W];
  assign fsel = st_q.config_r[lds_pkg::CFG_FSEL+:2];
  assign in_fire = st_q.fire != lds_pkg::LDS_F_OFF;
  assign fire_floor = s_atf && !s_run && (st_q.flr2 == fire_f);
  // Locked by key off, or by the auto stop window without a temporary run
  assign parked = !s_key || (st_q.config_r[lds_pkg::CFG_PARK] && st_q.clk_stop && !st_q.temp_run);

  // Hold time chosen by pending calls
  always_comb
  begin
    hold_sel = st_q.t_hold;
    if (s_lc && s_cc)
    begin
      hold_sel = 16'((st_q.t_hold << 1) - lds_pkg::TWO_S_TICKS);
    end
    else if (s_lc)
    begin
      hold_sel = st_q.t_hold - lds_pkg::TWO_S_TICKS;
    end
  end

  // Reads answer on the cycle after the request; writes never wait
  assign avs_waitrequest = (avs_read && !st_q.rvalid) ? 1'b1 : 1'b0;
  assign avs_readdata = st_q.rdata;

  // Next state
  always_comb
  begin
    st_d = st_q;
    st_d.s1 = raw;
    st_d.s2 = st_q.s1;
    st_d.mode1 = mode_sel_pin;
    st_d.mode2 = st_q.mode1;
    st_d.flr1 = floor_pin;
    st_d.flr2 = st_q.flr1;
    // Timebase divider
    st_d.tick = 1'b0;
    if (st_q.tick_cnt >= 32'(TICK_CYCLES - 1))
    begin
      st_d.tick_cnt = 32'h0000_0000;
      st_d.tick = 1'b1;
    end
    else
    begin
      st_d.tick_cnt = st_q.tick_cnt + 32'h0000_0001;
    end
    // Register bus
    st_d.rvalid = avs_read && !st_q.rvalid;
    if (avs_read && !st_q.rvalid)
    begin
      case (avs_address)
        lds_pkg::REG_TIMES0: st_d.rdata = {st_q.t_hold, st_q.t_motion};
        lds_pkg::REG_TIMES1: st_d.rdata = {st_q.t_brake, st_q.t_delay};
        lds_pkg::REG_TIMES2: st_d.rdata = {16'h0000, st_q.t_home};
        lds_pkg::REG_FLOORS: st_d.rdata = st_q.floors;
        lds_pkg::REG_CONFIG: st_d.rdata = st_q.config_r;
        lds_pkg::REG_STATUS: st_d.rdata = {22'h000000, st_q.temp_run, parked, st_q.fault,
                                           3'(st_q.fire), 3'(st_q.door), s_fire};
        default: st_d.rdata = 32'h0000_0000; // Unmapped reads zero
      endcase
    end
    if (avs_write)
    begin
      case (avs_address)
        lds_pkg::REG_TIMES0:
        begin
          st_d.t_motion = avs_writedata[15:0];
          st_d.t_hold = avs_writedata[31:16];
        end
        lds_pkg::REG_TIMES1:
        begin
          st_d.t_delay = avs_writedata[15:0];
          st_d.t_brake = avs_writedata[31:16];
        end
        lds_pkg::REG_TIMES2: st_d.t_home = avs_writedata[15:0];
        lds_pkg::REG_FLOORS: st_d.floors = avs_writedata;
        lds_pkg::REG_CONFIG: st_d.config_r = avs_writedata;
        lds_pkg::REG_CMD: st_d.clk_stop = avs_writedata[0]; // Software clock says stop window
        default: ; // Writes elsewhere dropped
      endcase
    end
    // Brake: jog drop closes brake, torque held for brake time
    st_d.jog_prev = s_jog;
    if (mode == lds_pkg::LDS_INSP && st_q.jog_prev && !s_jog)
    begin
      st_d.brake_cnt = st_q.t_brake;
    end
    else if (st_q.tick && st_q.brake_cnt != 16'h0000)
    begin
      st_d.brake_cnt = st_q.brake_cnt - 16'h0001;
    end
    // Key lock temporary run toggles on each off-on cycle inside stop window
    st_d.key_prev = s_key;
    if (!st_q.clk_stop)
    begin
      st_d.temp_run = 1'b0;
    end
    else if (s_key && !st_q.key_prev && st_q.config_r[lds_pkg::CFG_PARK])
    begin
      st_d.temp_run = !st_q.temp_run;
    end
    // Homing idle counter, reloaded on any call
    if (s_lc || s_cc || s_run || st_q.t_home == 16'h0000)
    begin
      st_d.home_cnt = st_q.t_home;
    end
    else if (st_q.tick && st_q.home_cnt != 16'h0000)
    begin
      st_d.home_cnt = st_q.home_cnt - 16'h0001;
    end
    // Fire sequence
    case (st_q.fire)
      lds_pkg::LDS_F_OFF:
        if (s_fire)
        begin
          st_d.fire = s_run ? lds_pkg::LDS_F_STOP : lds_pkg::LDS_F_RET;
        end
      lds_pkg::LDS_F_STOP:
        if (!s_run && s_atf)
        begin
          st_d.fire = lds_pkg::LDS_F_RET;
        end
      lds_pkg::LDS_F_RET:
        if (fire_floor)
        begin
          st_d.fire = lds_pkg::LDS_F_PARK;
        end
      lds_pkg::LDS_F_PARK:
        if (!s_fire && !s_fman && fsel != 2'h0)
        begin
          st_d.fire = lds_pkg::LDS_F_OFF;
        end
        else if (s_fman && fsel != 2'h1)
        begin
          st_d.fire = lds_pkg::LDS_F_OPER;
          st_d.oper_left = 1'b0;
        end
      lds_pkg::LDS_F_OPER:
      begin
        if (!fire_floor)
        begin
          st_d.oper_left = 1'b1;
        end
        if (!s_fman && (fire_floor || !st_q.oper_left))
        begin
          st_d.fire = (s_fire) ? lds_pkg::LDS_F_PARK : lds_pkg::LDS_F_OFF;
        end
      end
      default: st_d.fire = lds_pkg::LDS_F_OFF;
    endcase
    // Normal fire mode with both switches off leaves from park too
    if (st_q.fire == lds_pkg::LDS_F_PARK && fsel == 2'h0 && !s_fire && !s_fman)
    begin
      st_d.fire = lds_pkg::LDS_F_OFF;
    end
    // Landing event: outside fire service only a fresh stop opens the door, so an idle car stays shut after closing
    st_d.stop_prev = s_atf && !s_run;
    if (!(s_atf && !s_run))
    begin
      st_d.land_req = 1'b0;
    end
    else if (!st_q.stop_prev)
    begin
      st_d.land_req = 1'b1;
    end
    // Door sequencer
    st_d.close_latch = st_q.close_latch && !s_clim && !s_obtn;
    if (st_q.tick && st_q.door_cnt != 16'h0000)
    begin
      st_d.door_cnt = st_q.door_cnt - 16'h0001;
    end
    case (st_q.door)
      lds_pkg::LDS_D_IDLE:
        if (in_fire ? (fire_floor && !s_olim && st_q.fire == lds_pkg::LDS_F_PARK) :
            (st_q.land_req && s_atf && !s_run && !s_olim &&
             mode == lds_pkg::LDS_AUTO && !parked))
        begin
          st_d.land_req = 1'b0; // Landing served
          st_d.door = lds_pkg::LDS_D_OPEN;
          st_d.door_cnt = st_q.t_motion;
        end
      lds_pkg::LDS_D_OPEN:
        if (s_olim)
        begin
          st_d.door = lds_pkg::LDS_D_HOLD;
          st_d.door_cnt = hold_sel;
          st_d.delay_used = 1'b0;
        end
        else if (st_q.door_cnt == 16'h0000)
        begin
          st_d.door = lds_pkg::LDS_D_HOLD;
          st_d.door_cnt = hold_sel;
          st_d.delay_used = 1'b0;
        end
      lds_pkg::LDS_D_HOLD:
      begin
        if (st_q.config_r[lds_pkg::CFG_DLY_EN] && s_dbtn && !st_q.delay_used)
        begin
          st_d.door_cnt = st_q.t_delay;
          st_d.delay_used = 1'b1;
        end
        if (st_q.fire == lds_pkg::LDS_F_PARK)
        begin
          st_d.door_cnt = st_q.door_cnt;
        end
        else if (mode != lds_pkg::LDS_AUTO || st_q.fire != lds_pkg::LDS_F_OFF)
        begin
          if (s_cbtn)
          begin
            st_d.door = lds_pkg::LDS_D_CLOSE;
            st_d.close_latch = !st_q.config_r[lds_pkg::CFG_STYLE];
            st_d.door_cnt = st_q.t_motion;
          end
        end
        else if (s_cbtn || (st_q.door_cnt == 16'h0000 && !s_dbtn))
        begin
          st_d.door = lds_pkg::LDS_D_CLOSE;
          st_d.door_cnt = st_q.t_motion;
        end
      end
      lds_pkg::LDS_D_CLOSE:
        if (s_clim)
        begin
          st_d.door = lds_pkg::LDS_D_IDLE;
          st_d.fault = 1'b0;
        end
        else if (st_q.door_cnt == 16'h0000 && (mode == lds_pkg::LDS_AUTO && !in_fire))
        begin
          st_d.door = lds_pkg::LDS_D_OPEN;
          st_d.door_cnt = st_q.t_motion;
          st_d.fault = 1'b1;
        end
        else if (s_curt && !in_fire && mode == lds_pkg::LDS_AUTO)
        begin
          st_d.door = lds_pkg::LDS_D_OPEN;
          st_d.door_cnt = st_q.t_motion;
        end
        else if (in_fire && s_obtn)
        begin
          st_d.door = lds_pkg::LDS_D_OPEN;
          st_d.door_cnt = st_q.t_motion;
        end
      default: st_d.door = lds_pkg::LDS_D_IDLE;
    endcase
    // Fire begins at a landing with door open: close at once
    if (st_q.fire == lds_pkg::LDS_F_OFF && s_fire && st_q.door == lds_pkg::LDS_D_HOLD)
    begin
      st_d.door = lds_pkg::LDS_D_CLOSE;
      st_d.close_latch = 1'b1;
      st_d.door_cnt = st_q.t_motion;
    end
  end

  // Door outputs; jog modes need the button held
  logic jog_door;
  assign jog_door = mode == lds_pkg::LDS_INSP || st_q.fire == lds_pkg::LDS_F_OPER;
  always_comb
  begin
    door_open_cmd = st_q.door == lds_pkg::LDS_D_OPEN && !s_olim && st_q.door_cnt != 16'h0000;
    door_close_cmd = st_q.door == lds_pkg::LDS_D_CLOSE && !s_clim;
    if (jog_door)
    begin
      door_open_cmd = s_obtn && !s_olim;
      door_close_cmd = s_cbtn && !s_clim;
    end
    else if (st_q.door == lds_pkg::LDS_D_CLOSE && mode == lds_pkg::LDS_ATTEND &&
             !in_fire && !st_q.close_latch)
    begin
      door_close_cmd = s_cbtn && !s_clim;
    end
  end

  // Motion requests
  always_comb
  begin
    goto_req = 1'b0;
    goto_floor = home_f;
    if (in_fire && st_q.fire != lds_pkg::LDS_F_OPER)
    begin
      goto_req = st_q.fire == lds_pkg::LDS_F_RET;
      goto_floor = fire_f;
    end
    else if (!s_key && mode != lds_pkg::LDS_INSP && !s_cc && st_q.door == lds_pkg::LDS_D_IDLE)
    begin
      goto_req = 1'b1;
      goto_floor = park_f;
    end
    else if (mode == lds_pkg::LDS_AUTO && st_q.t_home != 16'h0000 &&
             st_q.home_cnt == 16'h0000 && !parked)
    begin
      goto_req = 1'b1;
    end
  end

  assign brake_release = s_jog && mode == lds_pkg::LDS_INSP && st_q.brake_cnt == 16'h0000;
  assign torque_hold = st_q.brake_cnt != 16'h0000;
  assign door_fault = st_q.fault;
  assign stop_nearest = st_q.fire == lds_pkg::LDS_F_STOP;
  assign cancel_calls = in_fire && st_q.fire != lds_pkg::LDS_F_OPER;
  assign service_locked = parked || st_q.fire == lds_pkg::LDS_F_PARK;
  assign one_call_only = st_q.fire == lds_pkg::LDS_F_OPER;

  // Register the whole state
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st_q <= '0;
      st_q.t_motion <= lds_pkg::RST_MOTION;
      st_q.t_hold <= lds_pkg::RST_HOLD;
      st_q.t_delay <= lds_pkg::RST_DELAY;
      st_q.t_brake <= lds_pkg::RST_BRAKE;
      st_q.t_home <= lds_pkg::RST_HOME;
      st_q.floors <= lds_pkg::RST_FLOORS;
      st_q.config_r <= lds_pkg::RST_CONFIG;
      st_q.door <= lds_pkg::LDS_D_IDLE;
      st_q.fire <= lds_pkg::LDS_F_OFF;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  a_close_limit_stop: assert property (@(posedge clk) disable iff (!rst_n)
    s_clim |-> !door_close_cmd) else $error("close output with close limit");
  a_brake_on_drop: assert property (@(posedge clk) disable iff (!rst_n)
    (mode == lds_pkg::LDS_INSP && $fell(s_jog)) |=> (!brake_release && torque_hold ||
    st_q.t_brake == 16'h0000)) else $error("brake not closed on jog drop");
  a_insp_jog_door: assert property (@(posedge clk) disable iff (!rst_n)
    (mode == lds_pkg::LDS_INSP && !s_obtn) |-> !door_open_cmd)
    else $error("inspection open without button");
  a_fire_stop_req: assert property (@(posedge clk) disable iff (!rst_n)
    (st_q.fire == lds_pkg::LDS_F_OFF && s_fire && s_run) |=> stop_nearest)
    else $error("fire while running did not stop");
  a_fire_cancel: assert property (@(posedge clk) disable iff (!rst_n)
    (st_q.fire == lds_pkg::LDS_F_RET) |-> (cancel_calls && goto_req && goto_floor == fire_f))
    else $error("fire return not requested");
  a_fire_exit: assert property (@(posedge clk) disable iff (!rst_n)
    (in_fire && s_fman) |=> in_fire) else $error("fire left with switch on");
  a_close_timeout: assert property (@(posedge clk) disable iff (!rst_n)
    (st_q.door == lds_pkg::LDS_D_CLOSE && st_q.door_cnt == 16'h0000 && !s_clim &&
    mode == lds_pkg::LDS_AUTO && !in_fire) |=> st_q.door == lds_pkg::LDS_D_OPEN)
    else $error("no reopen after close timeout");
  a_open_timeout: assert property (@(posedge clk) disable iff (!rst_n)
    (st_q.door == lds_pkg::LDS_D_OPEN && st_q.door_cnt == 16'h0000 && !jog_door)
    |-> !door_open_cmd) else $error("open drive past timeout");
  c_fire_cycle: cover property (@(posedge clk) disable iff (!rst_n)
    st_q.fire == lds_pkg::LDS_F_PARK ##1 st_q.fire == lds_pkg::LDS_F_OPER);
  c_door_reopen: cover property (@(posedge clk) disable iff (!rst_n)
    st_q.door == lds_pkg::LDS_D_CLOSE ##1 st_q.door == lds_pkg::LDS_D_OPEN);
  c_homing: cover property (@(posedge clk) disable iff (!rst_n) $rose(goto_req));
endmodule

// ==== hdl/lds_pkg.sv ====
// Functional notes
// - Jog drop closes brake, holds torque
// - Close timeout without close limit reopens door
// - Open timeout without open limit stops open
// - Limits end motion, timeout as fallback
// - Close limit stops close output at once
// - No calls: hold for hold time
// - Landing calls only: hold time minus 2s
// - Both calls: twice hold minus 2s
// - Delay button holds door for delay time
// - Attendant closes manually, jog or latched
// - Inspection door moves only while held
// - Fire while running: stop closed, return
// - Fire away: close now, reopen on button
// - Fire floor open hold, jog elsewhere
// - Idle homing time sends car home
// - Key off parks per mode
// - Key on, auto park: timed start/stop
// - Key toggle in stop allows temporary run
// - Fire select chooses three fire variants; code has two: 1 bars fireman operation, 0, 2 and 3 act alike
// - Two-step fire cancels calls, returns, stops
// - Fireman switch after return, one call
// - Fire ignores curtain, exits both off
package lds_pkg;
  // Timebase
  localparam int CLK_HZ = 100_000_000;
  localparam int TICK_MS = 100;
  localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam int TWO_S_MS = 2000;
  localparam logic [15:0] TWO_S_TICKS = 16'(TWO_S_MS / TICK_MS);
  // Avalon register word addresses
  localparam logic [3:0] REG_TIMES0 = 4'h0;
  localparam logic [3:0] REG_TIMES1 = 4'h1;
  localparam logic [3:0] REG_TIMES2 = 4'h2;
  localparam logic [3:0] REG_FLOORS = 4'h3;
  localparam logic [3:0] REG_CONFIG = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h5;
  localparam logic [3:0] REG_CMD = 4'h6;
  // Config field positions
  localparam int CFG_DLY_EN = 0;
  localparam int CFG_STYLE = 1;
  localparam int CFG_PARK = 2;
  localparam int CFG_FSEL = 3;
  // Reset values, times in 0.1s ticks
  localparam logic [15:0] RST_MOTION = 16'h0064;
  localparam logic [15:0] RST_HOLD = 16'h0032;
  localparam logic [15:0] RST_DELAY = 16'h0064;
  localparam logic [15:0] RST_BRAKE = 16'h0003;
  localparam logic [15:0] RST_HOME = 16'h0000;
  localparam logic [31:0] RST_FLOORS = 32'h0000_0000;
  localparam logic [31:0] RST_CONFIG = 32'h0000_0000;
  typedef enum logic [1:0] {LDS_AUTO, LDS_ATTEND, LDS_INSP} lds_mode_t;
  typedef enum logic [2:0] {LDS_D_IDLE, LDS_D_OPEN, LDS_D_HOLD, LDS_D_CLOSE} lds_door_t;
  typedef enum logic [2:0] {LDS_F_OFF, LDS_F_STOP, LDS_F_RET, LDS_F_PARK, LDS_F_OPER} lds_fire_t;
endpackage

// ==== sim/lds_door_model.sv ====
`timescale 1ns/1ps
// Door operator with limit switches; travel takes TRAVEL cycles each way
module lds_door_model
#(
  parameter int TRAVEL = 20
)
(
  input wire logic clk,
  input wire logic limits_ok,
  input wire logic door_open_cmd,
  input wire logic door_close_cmd,
  output logic open_limit,
  output logic close_limit
);
  // Door position, 0 is fully closed
  int pos = 0;
  // Panel moves one step per cycle while driven
  always @(posedge clk)
  begin
    if (door_open_cmd && pos < TRAVEL)
      pos <= pos + 1;
    else if (door_close_cmd && pos > 0)
      pos <= pos - 1;
  end
  // A broken switch never closes, so it reads a steady low level
  assign open_limit = limits_ok && (pos == TRAVEL);
  assign close_limit = limits_ok && (pos == 0);
endmodule

// ==== sim/test_lift_door_and_mode_sequencer.sv ====
`timescale 1ns/1ps
module test_lift_door_and_mode_sequencer;
  localparam int TK = 10; // Cycles per tick, shortened for simulation
  logic clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic avs_waitrequest, limits_ok = 1'b1;
  logic [1:0] mode_sel_pin = 2'h0;
  logic jog_up_pin = 1'b0, jog_down_pin = 1'b0, open_btn_pin = 1'b0, close_btn_pin = 1'b0;
  logic delay_btn_pin = 1'b0, curtain_pin = 1'b0, key_lock_input = 1'b1;
  logic fire_switch_input = 1'b0, fireman_switch_pin = 1'b0, landing_call_pin = 1'b0;
  logic car_call_pin = 1'b0, running_pin = 1'b0, at_floor_pin = 1'b0;
  logic [4:0] floor_pin = 5'h03, goto_floor;
  logic open_limit_pin, close_limit_pin, brake_release, torque_hold, door_open_cmd;
  logic door_close_cmd, door_fault, stop_nearest, cancel_calls, goto_req;
  logic service_locked, one_call_only;
  int n_errors = 0, cmp_count = 0, cyc = 0, n, t1, t2;
  // Watched outputs: 0 open, 1 close, 2 brake, 3 torque
  wire [3:0] obs = {torque_hold, brake_release, door_close_cmd, door_open_cmd};
  // Register reset table; 6 is the command word, F is unmapped
  logic [3:0] ra [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'hF};
  logic [31:0] rv [7] = '{32'h0032_0064, 32'h0003_0064, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
  logic [31:0] hx [3] = '{32'd30, 32'd10, 32'd40}; // Hold ticks: none, landing, both

  always #5 clk = ~clk;

  lds_sequencer #(.FLOOR_W(5), .TICK_CYCLES(TK)) lds_sequencer_inst (.clk(clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .mode_sel_pin(mode_sel_pin), .jog_up_pin(jog_up_pin),
    .jog_down_pin(jog_down_pin), .open_limit_pin(open_limit_pin),
    .close_limit_pin(close_limit_pin), .open_btn_pin(open_btn_pin),
    .close_btn_pin(close_btn_pin), .delay_btn_pin(delay_btn_pin), .curtain_pin(curtain_pin),
    .key_lock_input(key_lock_input), .fire_switch_input(fire_switch_input),
    .fireman_switch_pin(fireman_switch_pin), .landing_call_pin(landing_call_pin),
    .car_call_pin(car_call_pin), .running_pin(running_pin), .at_floor_pin(at_floor_pin),
    .floor_pin(floor_pin), .brake_release(brake_release), .torque_hold(torque_hold),
    .door_open_cmd(door_open_cmd), .door_close_cmd(door_close_cmd),
    .door_fault(door_fault), .stop_nearest(stop_nearest), .cancel_calls(cancel_calls),
    .goto_req(goto_req), .goto_floor(goto_floor), .service_locked(service_locked),
    .one_call_only(one_call_only));

  lds_door_model #(.TRAVEL(20)) lds_door_model_inst (.clk(clk), .limits_ok(limits_ok),
    .door_open_cmd(door_open_cmd), .door_close_cmd(door_close_cmd),
    .open_limit(open_limit_pin), .close_limit(close_limit_pin));

  // Verdict and end of run
  task stop_test;
    if (n_errors == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Exact comparison on four-state values
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Duration must fall inside a window; tick phase and pin sync blur the edges
  task automatic rng(input string nm, input int lo, input int hi, input int got);
    cmp_count++;
    if (got < lo || got > hi)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask

  // One Avalon transfer; request holds until waitrequest is sampled low at a rising edge
  task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0)
    begin
      @(posedge clk);
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // Count falling edges until a watched output reaches a level
  task automatic wt(input int i, input logic v, output int c);
    c = 0;
    while (obs[i] !== v && c < 3000)
    begin
      @(negedge clk);
      c++;
    end
    rng("wait bound", 0, 2999, c);
  endtask

  // Short timings: motion 20 ticks, hold 30 ticks, fire floor 7
  task cfg;
    bus(4'h0, 1'b1, 32'h001E_0014);
    bus(4'hF, 1'b1, 32'hFFFF_FFFF);
    bus(4'h3, 1'b1, 32'h0007_0000);
    bus(4'h0, 1'b0, 32'h0);
    chk("times0", 32'h001E_0014, q);
    bus(4'hF, 1'b0, 32'h0);
    chk("unmapped", 32'h0, q);
  endtask

  // Leave the landing, set calls, land again
  task land(input logic lc, input logic cc);
    @(posedge clk);
    at_floor_pin <= 1'b0;
    landing_call_pin <= lc;
    car_call_pin <= cc;
    repeat (6) @(posedge clk);
    at_floor_pin <= 1'b1;
    wt(0, 1'b1, n);
  endtask

  // Hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      n_errors++;
      stop_test();
    end
  end

  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 7; i++)
    begin
      bus(ra[i], 1'b0, 32'h0);
      chk("reset value", rv[i], q);
    end
    cfg();
    // Open and close on limits, hold chosen by pending calls
    for (int i = 0; i < 3; i++)
    begin
      land(i > 0, i > 1);
      wt(0, 1'b0, t1);
      rng("open on limit", 20, 26, t1);
      wt(1, 1'b1, t2);
      rng("hold", int'(hx[i]) * TK - 12, int'(hx[i]) * TK + 12, t2);
      wt(1, 1'b0, t1);
      rng("close on limit", 20, 26, t1);
    end
    // Dead limits: motion timeout ends open, close timeout reopens
    @(posedge clk);
    limits_ok <= 1'b0;
    land(1'b0, 1'b0);
    wt(0, 1'b0, t1);
    rng("open timeout", 20 * TK - 12, 20 * TK + 12, t1);
    wt(1, 1'b1, t2);
    wt(0, 1'b1, t2);
    rng("close timeout", 20 * TK - 12, 20 * TK + 12, t2);
    @(negedge clk);
    chk("door fault", 32'h1, 32'(door_fault));
    // Mid-run reset, then inspection mode
    @(posedge clk);
    rst_n <= 1'b0;
    limits_ok <= 1'b1;
    mode_sel_pin <= 2'h2;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    cfg();
    open_btn_pin <= 1'b1;
    wt(0, 1'b1, n);
    repeat (5) @(posedge clk);
    open_btn_pin <= 1'b0;
    repeat (6) @(negedge clk);
    chk("jog open release", 32'h0, 32'(door_open_cmd));
    @(posedge clk);
    jog_up_pin <= 1'b1;
    repeat (20) @(negedge clk);
    chk("brake open", 32'h1, 32'(brake_release));
    @(posedge clk);
    jog_up_pin <= 1'b0;
    repeat (6) @(negedge clk);
    chk("brake closed", 32'h0, 32'(brake_release));
    chk("torque held", 32'h1, 32'(torque_hold));
    repeat (40) @(negedge clk);
    chk("torque dropped", 32'h0, 32'(torque_hold));
    @(posedge clk);
    key_lock_input <= 1'b0;
    repeat (6) @(negedge clk);
    chk("locked", 32'h1, 32'(service_locked));
    // Fire while running in automatic mode
    @(posedge clk);
    key_lock_input <= 1'b1;
    mode_sel_pin <= 2'h0;
    at_floor_pin <= 1'b0;
    running_pin <= 1'b1;
    fire_switch_input <= 1'b1;
    repeat (8) @(negedge clk);
    chk("stop nearest", 32'h1, 32'(stop_nearest));
    @(posedge clk);
    running_pin <= 1'b0;
    at_floor_pin <= 1'b1;
    repeat (10) @(negedge clk);
    chk("no open away", 32'h0, 32'(door_open_cmd));
    chk("return floor", 32'h7, 32'(goto_floor));
    stop_test();
  end
endmodule
